//--- serial_port_map.vh
// Register indices, field positions, reset values and timing constants of the serial port
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH

// Register indices; byte address is four times the index
`define IDX_DATA 4'h0
`define IDX_STATUS 4'h1
`define IDX_COMMAND 4'h2
`define IDX_CONTROL 4'h3

// Command register fields
`define CMD_DTR 0
`define CMD_IRD 1
`define CMD_TIC_LO 2
`define CMD_ECHO 4
`define CMD_PME 5
`define CMD_PMC_LO 6
// Bits kept across a programmed reset
`define CMD_SOFT_KEEP 8'he0

// Control register fields
`define CTL_BAUD_LO 0
`define CTL_RCS 4
`define CTL_WL_LO 5
`define CTL_SBN 7

// Status register fields
`define ST_PE 0
`define ST_FE 1
`define ST_OVR 2
`define ST_RXF 3
`define ST_TXE 4
`define ST_IRQ 7

// Reset values
`define CMD_RESET 8'h00
`define CTL_RESET 8'h1e

// Timing: board clock, oversampling and stop length in half bits
`define CLK_HZ 25000000
`define OVERSAMPLE 16
`define TICK_LAST 4'hf
`define HALF_BIT_TICKS 6'h08
`define START_MID 4'h7

// Baud rates per select code
`define BAUD_1 50
`define BAUD_2 75
`define BAUD_3 110
`define BAUD_4 135
`define BAUD_5 150
`define BAUD_6 300
`define BAUD_7 600
`define BAUD_8 1200
`define BAUD_9 1800
`define BAUD_10 2400
`define BAUD_11 3600
`define BAUD_12 4800
`define BAUD_13 7200
`define BAUD_14 9600
`define BAUD_15 19200

`endif

//--- baud_tick.v
// Internal baud generator giving one pulse per sixteenth of a bit
`include "serial_port_map.vh"
module baud_tick (
    input wire ref_clk,
    input wire rstn,
    input wire [3:0] baud_select,
    output reg tick
);
    reg [15:0] cnt;
    wire [15:0] last;

    // Last divider count: clock cycles per oversample tick, rounded down, less one
    // rate per code
    function [15:0] divisor;
        input [3:0] code;
        integer rate;
        integer q;
        begin
            case (code)
                4'h1: rate = `BAUD_1;
                4'h2: rate = `BAUD_2;
                4'h3: rate = `BAUD_3;
                4'h4: rate = `BAUD_4;
                4'h5: rate = `BAUD_5;
                4'h6: rate = `BAUD_6;
                4'h7: rate = `BAUD_7;
                4'h8: rate = `BAUD_8;
                4'h9: rate = `BAUD_9;
                4'ha: rate = `BAUD_10;
                4'hb: rate = `BAUD_11;
                4'hc: rate = `BAUD_12;
                4'hd: rate = `BAUD_13;
                4'he: rate = `BAUD_14;
                default: rate = `BAUD_15;
            endcase
            q = `CLK_HZ / (`OVERSAMPLE * rate) - 1;
            divisor = q[15:0];
        end
    endfunction

    assign last = divisor(baud_select);

    // Free running divider; a rate change restarts at the next wrap
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt >= last) begin
            cnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

//--- tx_fifo2.v
// Two-entry buffer with valid and ready on both sides
module tx_fifo2 #(
    parameter WIDTH = 8
) (
    input wire ref_clk,
    input wire rstn,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointers and fill level; flush drops both entries
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else if (flush) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push)
                wr_ptr <= ~wr_ptr;
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push & ~pop)
                count <= count + 2'h1;
            else if (pop & ~push)
                count <= count - 2'h1;
        end
    end

    // Storage needs no reset; valid guards every read
    always @(posedge ref_clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule

//--- serial_port.v
// Asynchronous serial port with APB registers, baud generator and buffered transmitter
`include "serial_port_map.vh"

module serial_port #(
    parameter ADDR_W = 8
) (
    input wire ref_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg txd,
    input wire rxd,
    input wire external_rx_clock,
    output wire rts_n,
    output wire terminal_ready_n,
    output wire irq_n
);
    localparam TX_IDLE = 3'h0;
    localparam TX_START = 3'h1;
    localparam TX_DATA = 3'h2;
    localparam TX_PAR = 3'h3;
    localparam TX_STOP = 3'h4;
    localparam RX_IDLE = 3'h0;
    localparam RX_START = 3'h1;
    localparam RX_DATA = 3'h2;
    localparam RX_PAR = 3'h3;
    localparam RX_STOP = 3'h4;

    reg [7:0] serial_command;
    reg [7:0] serial_control;
    reg [7:0] rx_data;
    reg rx_full;
    reg parity_err;
    reg framing_err;
    reg overrun;
    reg irq_occurred;
    reg tx_empty_d;
    reg [1:0] rxd_sync;
    reg [2:0] rxc_sync;
    reg [2:0] tx_state;
    reg [5:0] tx_cnt;
    reg [2:0] tx_bitn;
    reg [7:0] tx_shift;
    reg tx_par;
    reg tx_line;
    reg [2:0] rx_state;
    reg [3:0] rx_cnt;
    reg [2:0] rx_bitn;
    reg [7:0] rx_shift;
    reg rx_par_bit;
    reg next_txd;

    wire int_tick;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [7:0] fifo_out_data;

    // Field views of the two configuration registers
    wire [1:0] parity_select = serial_command[`CMD_PMC_LO+1:`CMD_PMC_LO];
    wire parity_enable = serial_command[`CMD_PME];
    wire echo_mode = serial_command[`CMD_ECHO];
    wire [1:0] transmit_control = serial_command[`CMD_TIC_LO+1:`CMD_TIC_LO];
    wire rx_irq_disable = serial_command[`CMD_IRD];
    wire terminal_ready = serial_command[`CMD_DTR];
    wire stop_bit_select = serial_control[`CTL_SBN];
    wire [1:0] word_length = serial_control[`CTL_WL_LO+1:`CTL_WL_LO];
    wire rx_clock_source = serial_control[`CTL_RCS];
    wire [3:0] baud_select = serial_control[`CTL_BAUD_LO+3:`CTL_BAUD_LO];

    // APB decode; only aligned words of the four registers are mapped
    wire [3:0] idx = paddr[5:2];
    wire mapped = (paddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}}) && (paddr[1:0] == 2'h0) && (idx <= `IDX_CONTROL);
    wire access = psel & penable;
    wire wr_data = access & pwrite & mapped & (idx == `IDX_DATA);
    // A data write waits while both buffer entries are taken
    assign pready = ~wr_data | fifo_in_ready;
    assign pslverr = access & ~mapped;
    wire done = access & pready & mapped;
    wire wr_cmd = done & pwrite & (idx == `IDX_COMMAND);
    wire wr_ctl = done & pwrite & (idx == `IDX_CONTROL);
    wire rd_data = done & ~pwrite & (idx == `IDX_DATA);
    wire rd_status = done & ~pwrite & (idx == `IDX_STATUS);
    wire soft_rst = done & pwrite & (idx == `IDX_STATUS);

    wire [3:0] data_bits = 4'h8 - {2'h0, word_length};
    wire [7:0] data_mask = 8'hff >> word_length;
    wire [2:0] stop_halves = ~stop_bit_select ? 3'h2 :
                             (word_length == 2'h3 && !parity_enable) ? 3'h3 :
                             (word_length == 2'h0 && parity_enable) ? 3'h2 : 3'h4;
    wire [5:0] stop_ticks = {3'h0, stop_halves} * `HALF_BIT_TICKS;
    wire [5:0] stop_last = stop_ticks - 6'h1;

    wire ext_tick = rxc_sync[1] & ~rxc_sync[2];
    wire tx_tick = (baud_select == 4'h0) ? ext_tick : int_tick;
    wire rx_tick = rx_clock_source ? tx_tick : ext_tick;

    wire tx_en = terminal_ready & (transmit_control != 2'h0);
    wire tx_break = terminal_ready & (transmit_control == 2'h3);
    wire tx_empty = ~fifo_out_valid;
    assign fifo_out_ready = (tx_state == TX_IDLE) & tx_en & ~tx_break & ~soft_rst;

    assign rts_n = ~(echo_mode | (transmit_control != 2'h0));
    assign terminal_ready_n = ~terminal_ready;
    assign irq_n = ~irq_occurred;

    function par_of;
        input [7:0] d;
        input [7:0] m;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: par_of = ~(^(d & m));
                2'h1: par_of = ^(d & m);
                2'h2: par_of = 1'b1;
                default: par_of = 1'b0;
            endcase
        end
    endfunction

    baud_tick u_baud (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .baud_select(baud_select),
        .tick(int_tick)
    );

    tx_fifo2 #(
        .WIDTH(8)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .flush(soft_rst),
        .in_valid(wr_data),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Line inputs pass two flops; the third only feeds the clock edge detect
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rxd_sync <= 2'h3;
            rxc_sync <= 3'h0;
        end else begin
            rxd_sync <= {rxd_sync[0], rxd};
            rxc_sync <= {rxc_sync[1:0], external_rx_clock};
        end
    end

    // Configuration registers; programmed reset keeps only the parity bits of command and leaves control unchanged
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            serial_command <= `CMD_RESET;
            serial_control <= `CTL_RESET;
        end else begin
            if (soft_rst)
                serial_command <= serial_command & `CMD_SOFT_KEEP;
            else if (wr_cmd)
                serial_command <= pwdata[7:0];
            if (wr_ctl)
                serial_control <= pwdata[7:0];
        end
    end

    // Transmit sequencer; leaving the enabled state aborts the character at once
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_state <= TX_IDLE;
            tx_cnt <= 6'h00;
            tx_bitn <= 3'h0;
            tx_shift <= 8'h00;
            tx_par <= 1'b0;
            tx_line <= 1'b1;
        end else if (soft_rst | ~tx_en) begin
            tx_state <= TX_IDLE;
            tx_line <= 1'b1;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_cnt <= 6'h00;
                    if (fifo_out_ready & fifo_out_valid) begin
                        tx_state <= TX_START;
                        tx_shift <= fifo_out_data;
                        tx_par <= par_of(fifo_out_data, data_mask, parity_select);
                        tx_line <= 1'b0;
                    end
                end
                TX_START: if (tx_tick) begin
                    if (tx_cnt[3:0] == `TICK_LAST) begin
                        tx_cnt <= 6'h00;
                        tx_bitn <= 3'h0;
                        tx_state <= TX_DATA;
                        tx_line <= tx_shift[0];
                    end else
                        tx_cnt <= tx_cnt + 6'h1;
                end
                TX_DATA: if (tx_tick) begin
                    if (tx_cnt[3:0] == `TICK_LAST) begin
                        tx_cnt <= 6'h00;
                        if ({1'b0, tx_bitn} == data_bits - 4'h1) begin
                            tx_state <= parity_enable ? TX_PAR : TX_STOP;
                            tx_line <= parity_enable ? tx_par : 1'b1;
                        end else begin
                            tx_shift <= tx_shift >> 1;
                            tx_line <= tx_shift[1];
                            tx_bitn <= tx_bitn + 3'h1;
                        end
                    end else
                        tx_cnt <= tx_cnt + 6'h1;
                end
                TX_PAR: if (tx_tick) begin
                    if (tx_cnt[3:0] == `TICK_LAST) begin
                        tx_cnt <= 6'h00;
                        tx_state <= TX_STOP;
                        tx_line <= 1'b1;
                    end else
                        tx_cnt <= tx_cnt + 6'h1;
                end
                TX_STOP: if (tx_tick) begin
                    if (tx_cnt >= stop_last)
                        tx_state <= TX_IDLE;
                    else
                        tx_cnt <= tx_cnt + 6'h1;
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // Line driver: echo mirrors the receive pin, break holds it low
    always @* begin
        if (echo_mode)
            next_txd = rxd_sync[1];
        else if (tx_break)
            next_txd = 1'b0;
        else
            next_txd = tx_line;
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            txd <= 1'b1;
        else
            txd <= next_txd;
    end

    // Receive sequencer; terminal-ready is only checked before a start bit
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_state <= RX_IDLE;
            rx_cnt <= 4'h0;
            rx_bitn <= 3'h0;
            rx_shift <= 8'h00;
            rx_par_bit <= 1'b0;
        end else if (soft_rst) begin
            rx_state <= RX_IDLE;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    rx_cnt <= 4'h0;
                    // no new character once not ready
                    if (terminal_ready & ~rxd_sync[1])
                        rx_state <= RX_START;
                end
                RX_START: if (rx_tick) begin
                    // Recheck at mid start bit to reject glitches
                    if (rx_cnt == `START_MID) begin
                        rx_cnt <= 4'h0;
                        rx_bitn <= 3'h0;
                        rx_state <= rxd_sync[1] ? RX_IDLE : RX_DATA;
                    end else
                        rx_cnt <= rx_cnt + 4'h1;
                end
                RX_DATA: if (rx_tick) begin
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == `TICK_LAST) begin
                        rx_shift <= {rxd_sync[1], rx_shift[7:1]};
                        rx_bitn <= rx_bitn + 3'h1;
                        if ({1'b0, rx_bitn} == data_bits - 4'h1)
                            rx_state <= parity_enable ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: if (rx_tick) begin
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == `TICK_LAST) begin
                        rx_par_bit <= rxd_sync[1];
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: if (rx_tick) begin
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == `TICK_LAST)
                        rx_state <= RX_IDLE;
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // Character completes at the middle of the first stop bit
    wire rx_done = ~soft_rst & (rx_state == RX_STOP) & rx_tick & (rx_cnt == `TICK_LAST);
    wire [7:0] rx_word = rx_shift >> word_length;
    wire rx_par_bad = parity_enable & ~parity_select[1] &
                      (rx_par_bit != par_of(rx_word, data_mask, parity_select));

    // receive status; a new character wins over a clearing read
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_data <= 8'h00;
            rx_full <= 1'b0;
            parity_err <= 1'b0;
            framing_err <= 1'b0;
            overrun <= 1'b0;
        end else if (soft_rst) begin
            rx_full <= 1'b0;
            parity_err <= 1'b0;
            framing_err <= 1'b0;
            overrun <= 1'b0;
        end else begin
            if (rd_data) begin
                rx_full <= 1'b0;
                parity_err <= 1'b0;
                framing_err <= 1'b0;
                overrun <= 1'b0;
            end
            if (rx_done) begin
                // Unread data is kept; the newer character is lost
                if (rx_full & ~rd_data)
                    overrun <= 1'b1;
                else begin
                    rx_data <= rx_word;
                    rx_full <= 1'b1;
                    parity_err <= rx_par_bad;
                    framing_err <= ~rxd_sync[1];
                end
            end
        end
    end

    // Interrupt flag: status read clears it, a same-cycle event keeps it set
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_occurred <= 1'b0;
            tx_empty_d <= 1'b1;
        end else begin
            tx_empty_d <= tx_empty;
            if (soft_rst)
                irq_occurred <= 1'b0;
            // transmit request only for code 01
            else if ((rx_done & ~rx_irq_disable) |
                     (tx_empty & ~tx_empty_d & (transmit_control == 2'h1)))
                irq_occurred <= 1'b1;
            else if (rd_status)
                irq_occurred <= 1'b0;
        end
    end

    // Read data mux; unused upper bits read zero
    always @* begin
        prdata = 32'h00000000;
        if (psel & mapped & ~pwrite) begin
            case (idx)
                `IDX_DATA: prdata[7:0] = rx_data;
                `IDX_STATUS: begin
                    prdata[`ST_PE] = parity_err;
                    prdata[`ST_FE] = framing_err;
                    prdata[`ST_OVR] = overrun;
                    prdata[`ST_RXF] = rx_full;
                    prdata[`ST_TXE] = tx_empty;
                    prdata[`ST_IRQ] = irq_occurred;
                end
                `IDX_COMMAND: prdata[7:0] = serial_command;
                `IDX_CONTROL: prdata[7:0] = serial_control;
                default: prdata = 32'h00000000;
            endcase
        end
    end
endmodule

//--- serial_port_chk.sv
// Property checker for the serial port pins and register side effects
module serial_port_chk #(
    parameter ADDR_W = 8
) (
    input wire ref_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire txd,
    input wire rts_n,
    input wire terminal_ready_n,
    input wire irq_n
);
    logic [7:0] cmd;
    wire wr = psel && penable && pready && pwrite;
    wire rd_st = psel && penable && pready && !pwrite && paddr == 8'h04;

    // Shadow of the command register; a status write keeps only the parity bits
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmd <= 8'h00;
        end else if (wr && paddr == 8'h08) begin
            cmd <= pwdata[7:0];
        end else if (wr && paddr == 8'h04) begin
            cmd <= cmd & 8'he0;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_ready_level: assert property (terminal_ready_n == !cmd[0])
        else $error("terminal ready wrong");
    a_rts_level: assert property (rts_n == !(cmd[4] || cmd[3:2] != 2'b00))
        else $error("rts wrong");
    a_tx_halt: assert property ((!cmd[0] && !cmd[4]) [*3] |-> txd)
        else $error("tx not stopped");
    a_tx_off: assert property ((cmd[3:2] == 2'b00 && !cmd[4]) [*3] |-> txd)
        else $error("tx not disabled");
    a_break_low: assert property ((cmd[0] && !cmd[4] && cmd[3:2] == 2'b11) [*2] |-> !txd)
        else $error("break missing");
    a_irq_cause: assert property ($fell(irq_n) |-> !$past(cmd[1]) || $past(cmd[3:2]) == 2'b01)
        else $error("irq while masked");
    a_status_clear: assert property (rd_st |-> ##[1:2] irq_n)
        else $error("irq not cleared");
    a_soft_reset: assert property (wr && paddr == 8'h04 |-> ##[1:2] (irq_n && txd))
        else $error("soft reset missed");
    a_idle_high: assert property ($rose(rstn) |-> txd)
        else $error("line not idle");

    // Main scenarios reached
    cover property (rd_st && !irq_n);
    cover property (cmd[3:2] == 2'b11 && !txd);
    cover property ($fell(irq_n));
endmodule

//--- line_partner.sv
// Line-side partner that sends characters onto the receive line
module line_partner #(
    parameter int BIT = 1296
) (
    input wire logic ref_clk,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;

    // Mark level between frames, as a pulled-up line would rest
    initial rxd = 1'b1;

    // start, data LSB first, parity, stop
    task automatic send(input logic [8:0] v);
        int k;
        rxd <= 1'b0;
        repeat (BIT) @(posedge ref_clk);
        for (k = 0; k < 9; k++) begin
            rxd <= v[k];
            repeat (BIT) @(posedge ref_clk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge ref_clk);
    endtask
endmodule

//--- serial_port_tb_top.sv
// Self-checking bench for the serial port
module serial_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Divider rounds down, so a bit is 16 whole ticks
    localparam int BIT = 16 * (25000000 / (16 * 19200));
    logic ref_clk, rstn, psel, penable, pwrite, external_rx_clock, err, stopb;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, rd;
    logic [8:0] got, e;
    logic [8:0] exp_q[$];
    wire [31:0] prdata;
    wire pready, pslverr, txd, rxd, rts_n, terminal_ready_n, irq_n;
    int mismatches, cmp_count, seed, n, i, j, nbits;

    serial_port serial_port_i (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .txd, .rxd, .external_rx_clock, .rts_n, .terminal_ready_n, .irq_n);
    line_partner #(.BIT(BIT)) line_partner_i (.ref_clk, .rxd);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask

    task results;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {$random(seed)} & 32'hffffff00 | {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 40000);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 40000) begin
            mismatches++;
            results;
        end
    endtask

    // Bounded wait until every noted frame has been compared
    task automatic drain;
        n = 0;
        while (exp_q.size() > 0 && n < 80000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 80000) begin
            mismatches++;
            results;
        end
    endtask

    // Decode a txd frame at mid bit whenever a character is expected
    always @(negedge txd) begin
        if (exp_q.size() > 0) begin
            got = 9'h000;
            repeat (BIT / 2) @(posedge ref_clk);
            for (i = 0; i < nbits; i++) begin
                repeat (BIT) @(posedge ref_clk);
                got[i] = txd;
            end
            repeat (BIT) @(posedge ref_clk);
            stopb = txd;
            e = exp_q.pop_front();
            check("tx frame", {stopb, got}, {1'b1, e});
        end
    end

    initial begin
        seed = 59;
        nbits = 9;
        {psel, penable, pwrite, external_rx_clock} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rstn = 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        apb(1'b0, 8'h08, 8'h00);
        check("command", rd, 32'h0);
        apb(1'b0, 8'h0c, 8'h00);
        check("control", rd, 32'h1e);
        apb(1'b0, 8'h10, 8'h00);
        check("unmapped err", err, 1);
        check("unmapped data", rd, 0);
        // nonzero baud code: 19200, internal clock, 8 bits, 1 stop
        apb(1'b1, 8'h0c, 8'h1f);
        apb(1'b1, 8'h08, 8'h69);
        @(posedge ref_clk);
        check("rts", rts_n, 0);
        // Four bytes back to back; the last stalls until the buffer frees
        for (j = 0; j < 4; j++) begin
            b = $random(seed);
            exp_q.push_back({^b, b});
            apb(1'b1, 8'h00, b);
        end
        drain;
        repeat (BIT) @(posedge ref_clk);
        // mark parity on five-bit characters, two stop bits
        apb(1'b1, 8'h0c, 8'hff);
        apb(1'b1, 8'h08, 8'ha9);
        nbits = 6;
        b = $random(seed);
        exp_q.push_back({4'h1, b[4:0]});
        apb(1'b1, 8'h00, b);
        drain;
        repeat (BIT) @(posedge ref_clk);
        nbits = 9;
        apb(1'b1, 8'h0c, 8'h1f);
        apb(1'b1, 8'h08, 8'h0d);
        repeat (4) @(posedge ref_clk);
        check("break", txd, 0);
        // Odd parity receive with receiver interrupts allowed
        apb(1'b1, 8'h08, 8'h29);
        b = $random(seed);
        line_partner_i.send({~^b, b});
        check("irq", irq_n, 0);
        apb(1'b0, 8'h04, 8'h00);
        check("status", rd, 32'h98);
        repeat (2) @(posedge ref_clk);
        check("irq", irq_n, 1);
        apb(1'b0, 8'h00, 8'h00);
        check("rx data", rd, {24'h0, b});
        // echo mirrors the line with RTS true; a masked receiver raises no irq
        apb(1'b1, 8'h08, 8'h33);
        b = $random(seed);
        exp_q.push_back({~^b, b});
        line_partner_i.send({~^b, b});
        drain;
        check("echo rts", rts_n, 0);
        check("masked irq", irq_n, 1);
        apb(1'b1, 8'h04, 8'h5a);
        apb(1'b0, 8'h08, 8'h00);
        check("command", rd, 32'h20);
        check("ready", terminal_ready_n, 1);
        results;
    end
endmodule

bind serial_port serial_port_chk #(.ADDR_W(ADDR_W)) serial_port_chk_i (.ref_clk, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .txd, .rts_n, .terminal_ready_n, .irq_n);
